// >>> common/gpm_defines.svh
// Register offsets, field codes, reset values and pin positions of the pin port.
`ifndef GPM_DEFINES_SVH
`define GPM_DEFINES_SVH
`define GPM_AW 12
`define GPM_OFF_DATA 12'h000
`define GPM_OFF_DIR 12'h004
`define GPM_OFF_SET 12'h008
`define GPM_OFF_CLR 12'h00c
`define GPM_OFF_SENSE 12'h010
`define GPM_OFF_BOTH 12'h014
`define GPM_OFF_POL 12'h018
`define GPM_OFF_MASK 12'h01c
`define GPM_OFF_STATUS 12'h020
`define GPM_OFF_MSTAT 12'h024
`define GPM_OFF_WAKE 12'h028
`define GPM_OFF_CFG 12'h100
`define GPM_CFG_RST_STD 6'h08
`define GPM_CFG_RST_BUS 6'h10
`define GPM_PAD_RST_STD 5'h04
`define GPM_PAD_RST_BUS 5'h00
`define GPM_PSENSE_IDLE 6'h27
`define GPM_PULL_NONE 2'h0
`define GPM_PULL_DOWN 2'h1
`define GPM_PULL_UP 2'h2
`define GPM_STRB_ALL 4'hf
`define GPM_PIN_SSEL 2
`define GPM_PIN_BUSCLK 4
`define GPM_PIN_BUSDATA 5
`define GPM_PIN_SCK 6
`define GPM_PIN_CTS 7
`endif

// >>> common/gpm_pkg.sv
// Types shared by the pin port: pin functions, pin configuration and peripheral links.
`default_nettype none
package gpm_pkg;
   typedef enum logic [1:0] {
      GPM_FUNC_GPIO = 2'h0,
      GPM_FUNC_ALT1 = 2'h1,
      GPM_FUNC_ALT2 = 2'h2
   } gpm_func_e;
   typedef struct packed {
      logic fast_plus;
      logic open_drain;
      logic [1:0] pull;
      gpm_func_e func;
   } gpm_pincfg_s;
   typedef struct packed {
      logic out;
      logic oe;
      logic pull_up;
      logic pull_down;
      logic high_sink;
   } gpm_pad_s;
   typedef struct packed {
      logic serial0_slave_select;
      logic serial0_slave_select_oe;
      logic serial0_shift_clock;
      logic serial0_shift_clock_oe;
      logic bus_clock_low;
      logic bus_data_low;
   } gpm_periph_out_s;
   typedef struct packed {
      logic serial0_slave_select;
      logic serial0_shift_clock;
      logic timer16_first_capture_in;
      logic clear_to_send;
      logic bus_clock;
      logic bus_data;
   } gpm_periph_in_s;
endpackage : gpm_pkg
`default_nettype wire

// >>> rtl/gpm_port.sv
// General purpose pin port with pin multiplexer, pin interrupts and APB registers.
`default_nettype none
`include "gpm_defines.svh"
// What this block does
// - Software sets each pin's direction independently at any time.
// - Set and clear registers change only the chosen output bits.
// - One write to the data register loads all output bits.
// - Each pin can interrupt on level, rising, falling or both edges.
// - Interrupt sensing works whatever function the pin mux selects.
// - Low pins also feed the wake-up start logic individually.
// - After reset pins are inputs with pull-up; bus pins have no pull.
// - Pull-up or pull-down is per pin; bus pins have none.
// - Pins offer a programmable open-drain output mode.
// - Bus pins used as port pins only drive low, never high.
// - Bus pins sink high current only with fast-mode-plus selected.
// - Pin configuration registers steer each shared pin to peripheral or port.
// - Shared pins take an alternate function only when selected.
// - Registers sit on a fast dedicated slave port with no wait states.
module gpm_port #(
   parameter int NUM_PINS = 12,
   parameter int START_PINS = 12
) (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`GPM_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Interrupt and wake-up start logic.
   output logic irq,
   output logic [START_PINS-1:0] wake_start,
   // Pads.
   input wire logic [NUM_PINS-1:0] pin_in,
   output var gpm_pkg::gpm_pad_s [NUM_PINS-1:0] pad,
   // Peripherals.
   input wire gpm_pkg::gpm_periph_out_s periph_drive,
   output var gpm_pkg::gpm_periph_in_s periph_sense
);
   import gpm_pkg::*;

   localparam logic [`GPM_AW-3:0] NP = (`GPM_AW-2)'(NUM_PINS);
   localparam logic [NUM_PINS-1:0] BUS_PINS = (NUM_PINS'(1) << `GPM_PIN_BUSCLK) | (NUM_PINS'(1) << `GPM_PIN_BUSDATA);

   logic [NUM_PINS-1:0] data_out;
   logic [NUM_PINS-1:0] dir;
   logic [NUM_PINS-1:0] sense;
   logic [NUM_PINS-1:0] both;
   logic [NUM_PINS-1:0] pol;
   logic [NUM_PINS-1:0] mask;
   logic [NUM_PINS-1:0] status;
   logic [NUM_PINS-1:0] clr_pend;
   logic [NUM_PINS-1:0] sync1;
   logic [NUM_PINS-1:0] sync2;
   logic [NUM_PINS-1:0] prev;
   logic [NUM_PINS-1:0] next_data_out;
   logic [NUM_PINS-1:0] next_dir;
   logic [NUM_PINS-1:0] next_sense;
   logic [NUM_PINS-1:0] next_both;
   logic [NUM_PINS-1:0] next_pol;
   logic [NUM_PINS-1:0] next_mask;
   logic [NUM_PINS-1:0] next_status;
   logic [NUM_PINS-1:0] next_clr_pend;
   logic [NUM_PINS-1:0] bm;
   logic [NUM_PINS-1:0] wv;
   logic [NUM_PINS-1:0] rise;
   logic [NUM_PINS-1:0] fall;
   logic [NUM_PINS-1:0] edge_ev;
   logic [NUM_PINS-1:0] clr_take;
   gpm_pincfg_s [NUM_PINS-1:0] cfg;
   gpm_pincfg_s [NUM_PINS-1:0] next_cfg;
   gpm_pad_s [NUM_PINS-1:0] next_pad;
   gpm_periph_in_s next_periph_sense;
   logic [31:0] next_prdata;
   logic next_pready;
   logic next_pslverr;
   logic next_irq;
   logic [START_PINS-1:0] next_wake_start;
   logic [`GPM_AW-1:0] cfg_off;
   logic [`GPM_AW-3:0] cfg_idx;
   logic cfg_hit;
   logic [31:0] rd_val;
   logic rd_ok;
   logic setup;
   logic wr_fire;
   logic rd_fire;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // Bus phases; every access completes in its first access cycle.
   assign setup = psel & ~penable;
   assign wr_fire = psel & penable & pready & pwrite;
   assign rd_fire = psel & penable & pready & ~pwrite;
   assign wv = pwdata[NUM_PINS-1:0] & bm;

   // Address decode and read data.
   always_comb begin
      cfg_off = paddr - `GPM_OFF_CFG;
      cfg_idx = cfg_off[`GPM_AW-1:2];
      cfg_hit = (paddr >= `GPM_OFF_CFG) && (cfg_off[1:0] == 2'h0) && (cfg_idx < NP);
      rd_ok = 1'b1;
      rd_val = 32'h0;
      if (paddr == `GPM_OFF_DATA) begin
         rd_val = 32'(sync2);
      end else if (paddr == `GPM_OFF_DIR) begin
         rd_val = 32'(dir);
      end else if ((paddr == `GPM_OFF_SET) || (paddr == `GPM_OFF_CLR)) begin
         rd_val = 32'h0;
      end else if (paddr == `GPM_OFF_SENSE) begin
         rd_val = 32'(sense);
      end else if (paddr == `GPM_OFF_BOTH) begin
         rd_val = 32'(both);
      end else if (paddr == `GPM_OFF_POL) begin
         rd_val = 32'(pol);
      end else if (paddr == `GPM_OFF_MASK) begin
         rd_val = 32'(mask);
      end else if (paddr == `GPM_OFF_STATUS) begin
         rd_val = 32'(status);
      end else if (paddr == `GPM_OFF_MSTAT) begin
         rd_val = 32'(status & mask);
      end else if (paddr == `GPM_OFF_WAKE) begin
         rd_val = 32'(wake_start);
      end else if (cfg_hit) begin
         rd_val = 32'(cfg[cfg_idx]);
      end else begin
         rd_ok = 1'b0;
      end
   end

   // Answer in the access cycle right after setup.
   always_comb begin
      next_pready = setup;
      next_pslverr = setup & ~rd_ok;
      next_prdata = setup ? rd_val : prdata;
   end

   // Port registers and interrupt flags.
   always_comb begin
      next_data_out = data_out;
      next_dir = dir;
      next_sense = sense;
      next_both = both;
      next_pol = pol;
      next_mask = mask;
      if (wr_fire) begin
         if (paddr == `GPM_OFF_DATA) begin
            next_data_out = (data_out & ~bm) | wv;
         end else if (paddr == `GPM_OFF_SET) begin
            next_data_out = data_out | wv;
         end else if (paddr == `GPM_OFF_CLR) begin
            next_data_out = data_out & ~wv;
         end else if (paddr == `GPM_OFF_DIR) begin
            next_dir = (dir & ~bm) | wv;
         end else if (paddr == `GPM_OFF_SENSE) begin
            next_sense = (sense & ~bm) | wv;
         end else if (paddr == `GPM_OFF_BOTH) begin
            next_both = (both & ~bm) | wv;
         end else if (paddr == `GPM_OFF_POL) begin
            next_pol = (pol & ~bm) | wv;
         end else if (paddr == `GPM_OFF_MASK) begin
            next_mask = (mask & ~bm) | wv;
         end
      end
      // Only flags shown by the read are cleared; a new edge always wins.
      next_clr_pend = (setup && (paddr == `GPM_OFF_STATUS)) ? status : clr_pend;
      clr_take = (rd_fire && (paddr == `GPM_OFF_STATUS)) ? clr_pend : '0;
      rise = sync2 & ~prev;
      fall = ~sync2 & prev;
      edge_ev = (both & (rise | fall)) | (~both & pol & rise) | (~both & ~pol & fall);
      next_status = (sense & ~(sync2 ^ pol)) | (~sense & ((status & ~clr_take) | edge_ev));
      next_irq = |(status & mask);
      next_wake_start = sync2[START_PINS-1:0];
   end

   // Peripheral inputs; an unrouted input rests at its idle level.
   always_comb begin
      next_periph_sense = gpm_periph_in_s'(`GPM_PSENSE_IDLE);
      if (cfg[`GPM_PIN_SSEL].func == GPM_FUNC_ALT1) begin
         next_periph_sense.serial0_slave_select = sync2[`GPM_PIN_SSEL];
      end
      if (cfg[`GPM_PIN_SSEL].func == GPM_FUNC_ALT2) begin
         next_periph_sense.timer16_first_capture_in = sync2[`GPM_PIN_SSEL];
      end
      if (cfg[`GPM_PIN_SCK].func == GPM_FUNC_ALT1) begin
         next_periph_sense.serial0_shift_clock = sync2[`GPM_PIN_SCK];
      end
      if (cfg[`GPM_PIN_CTS].func == GPM_FUNC_ALT1) begin
         next_periph_sense.clear_to_send = sync2[`GPM_PIN_CTS];
      end
      if (cfg[`GPM_PIN_BUSCLK].func == GPM_FUNC_ALT1) begin
         next_periph_sense.bus_clock = sync2[`GPM_PIN_BUSCLK];
      end
      if (cfg[`GPM_PIN_BUSDATA].func == GPM_FUNC_ALT1) begin
         next_periph_sense.bus_data = sync2[`GPM_PIN_BUSDATA];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         data_out <= '0;
         dir <= '0;
         sense <= '0;
         both <= '0;
         pol <= '0;
         mask <= '0;
         status <= '0;
         clr_pend <= '0;
         sync1 <= '0;
         sync2 <= '0;
         prev <= '0;
         prdata <= 32'h0;
         pready <= 1'b0;
         pslverr <= 1'b0;
         irq <= 1'b0;
         wake_start <= '0;
         periph_sense <= gpm_periph_in_s'(`GPM_PSENSE_IDLE);
      end else begin
         data_out <= next_data_out;
         dir <= next_dir;
         sense <= next_sense;
         both <= next_both;
         pol <= next_pol;
         mask <= next_mask;
         status <= next_status;
         clr_pend <= next_clr_pend;
         sync1 <= pin_in;
         sync2 <= sync1;
         prev <= sync2;
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
         irq <= next_irq;
         wake_start <= next_wake_start;
         periph_sense <= next_periph_sense;
      end
   end

   // Per-pin configuration, pad drive and checks.
   for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
      gpm_pincfg_s ncfg;
      gpm_pad_s npad;
      assign bm[i] = pstrb[i / 8];
      always_comb begin
         ncfg = cfg[i];
         if (wr_fire && cfg_hit && (cfg_idx == (`GPM_AW-2)'(i)) && pstrb[0]) begin
            ncfg = gpm_pincfg_s'(pwdata[$bits(gpm_pincfg_s)-1:0]);
         end
         if (BUS_PINS[i]) begin
            ncfg.pull = `GPM_PULL_NONE;
            ncfg.open_drain = 1'b1;
         end else begin
            ncfg.fast_plus = 1'b0;
         end
      end
      assign next_cfg[i] = ncfg;
      always_comb begin
         npad.pull_up = (cfg[i].pull == `GPM_PULL_UP);
         npad.pull_down = (cfg[i].pull == `GPM_PULL_DOWN);
         npad.high_sink = BUS_PINS[i] & cfg[i].fast_plus;
         if (cfg[i].open_drain) begin
            npad.out = 1'b0;
            npad.oe = dir[i] & ~data_out[i];
         end else begin
            npad.out = data_out[i];
            npad.oe = dir[i];
         end
         if ((i == `GPM_PIN_SSEL) && (cfg[i].func == GPM_FUNC_ALT1)) begin
            npad.out = periph_drive.serial0_slave_select;
            npad.oe = periph_drive.serial0_slave_select_oe;
         end else if ((i == `GPM_PIN_SCK) && (cfg[i].func == GPM_FUNC_ALT1)) begin
            npad.out = periph_drive.serial0_shift_clock;
            npad.oe = periph_drive.serial0_shift_clock_oe;
         end else if ((i == `GPM_PIN_BUSCLK) && (cfg[i].func == GPM_FUNC_ALT1)) begin
            npad.out = 1'b0;
            npad.oe = periph_drive.bus_clock_low;
         end else if ((i == `GPM_PIN_BUSDATA) && (cfg[i].func == GPM_FUNC_ALT1)) begin
            npad.out = 1'b0;
            npad.oe = periph_drive.bus_data_low;
         end else if (((i == `GPM_PIN_SSEL) && (cfg[i].func == GPM_FUNC_ALT2)) ||
                      ((i == `GPM_PIN_CTS) && (cfg[i].func == GPM_FUNC_ALT1))) begin
            npad.out = 1'b0;
            npad.oe = 1'b0;
         end
      end
      assign next_pad[i] = npad;
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            cfg[i] <= BUS_PINS[i] ? gpm_pincfg_s'(`GPM_CFG_RST_BUS) : gpm_pincfg_s'(`GPM_CFG_RST_STD);
            pad[i] <= BUS_PINS[i] ? gpm_pad_s'(`GPM_PAD_RST_BUS) : gpm_pad_s'(`GPM_PAD_RST_STD);
         end else begin
            cfg[i] <= next_cfg[i];
            pad[i] <= next_pad[i];
         end
      end

      a_edge_both: assert property (
         (!sense[i] && both[i] && !sync2[i] && prev[i]) |=> status[i])
         else $error("falling edge in both-edge mode not flagged");
      a_sense_any_func: assert property (
         (cfg[i].func != GPM_FUNC_GPIO && !sense[i] && !both[i] && pol[i] && sync2[i] && !prev[i]) |=> status[i])
         else $error("edge lost while pin routed to peripheral");
      a_edge_hold: assert property (
         (!sense[i] && !next_sense[i] && status[i] && !clr_take[i]) |=> status[i])
         else $error("latched edge flag dropped without a read");
      a_level_follow: assert property (
         (sense[i] && next_sense[i]) |=> (status[i] == ($past(sync2[i]) ~^ $past(pol[i]))))
         else $error("level flag does not follow pin");
      a_od_never_high: assert property (
         $past(cfg[i].open_drain && cfg[i].func == GPM_FUNC_GPIO) |-> !(pad[i].oe && pad[i].out))
         else $error("open-drain pin driven high");
   end

   a_dir_write: assert property (
      (wr_fire && paddr == `GPM_OFF_DIR && pstrb == `GPM_STRB_ALL) |=> dir == $past(pwdata[NUM_PINS-1:0]))
      else $error("direction write not applied");
   a_set_bits: assert property (
      (wr_fire && paddr == `GPM_OFF_SET && pstrb == `GPM_STRB_ALL)
      |=> data_out == ($past(data_out) | $past(pwdata[NUM_PINS-1:0])))
      else $error("set write changed wrong bits");
   a_clr_bits: assert property (
      (wr_fire && paddr == `GPM_OFF_CLR && pstrb == `GPM_STRB_ALL)
      |=> data_out == ($past(data_out) & ~$past(pwdata[NUM_PINS-1:0])))
      else $error("clear write changed wrong bits");
   a_data_full: assert property (
      (wr_fire && paddr == `GPM_OFF_DATA && pstrb == `GPM_STRB_ALL) |=> data_out == $past(pwdata[NUM_PINS-1:0]))
      else $error("full data write not applied");
   a_wake_follow: assert property (
      wake_start == $past(sync2[START_PINS-1:0]))
      else $error("wake-up output lags wrongly");
   a_reset_input: assert property (
      $rose(presetn) |-> (pad[`GPM_PIN_SSEL].pull_up && !pad[`GPM_PIN_SSEL].oe && !pad[`GPM_PIN_BUSCLK].pull_up))
      else $error("reset pad state wrong");
   a_bus_no_pull: assert property (
      !pad[`GPM_PIN_BUSCLK].pull_up && !pad[`GPM_PIN_BUSCLK].pull_down && !pad[`GPM_PIN_BUSDATA].pull_up)
      else $error("bus pin has a pull enabled");
   a_bus_od: assert property (
      !(pad[`GPM_PIN_BUSCLK].oe && pad[`GPM_PIN_BUSCLK].out) && !(pad[`GPM_PIN_BUSDATA].oe && pad[`GPM_PIN_BUSDATA].out))
      else $error("bus pin driven high");
   a_fast_sink: assert property (
      pad[`GPM_PIN_BUSDATA].high_sink == $past(cfg[`GPM_PIN_BUSDATA].fast_plus))
      else $error("high sink not tied to fast-mode-plus");
   a_mux_shift: assert property (
      $past(cfg[`GPM_PIN_SCK].func == GPM_FUNC_ALT1)
      |-> (pad[`GPM_PIN_SCK].out == $past(periph_drive.serial0_shift_clock)
           && pad[`GPM_PIN_SCK].oe == $past(periph_drive.serial0_shift_clock_oe)))
      else $error("shift clock not routed to pin");
   a_gpio_default: assert property (
      (cfg[`GPM_PIN_CTS].func != GPM_FUNC_ALT1 && !cfg[`GPM_PIN_CTS].open_drain)
      |=> (pad[`GPM_PIN_CTS].out == $past(data_out[`GPM_PIN_CTS]) && pad[`GPM_PIN_CTS].oe == $past(dir[`GPM_PIN_CTS])))
      else $error("unselected pin not port driven");
   a_zero_wait: assert property (
      (psel && !penable) |=> (pready ##1 !pready))
      else $error("access not answered at once");
   a_sync_two: assert property (
      $past(presetn, 2) |-> sync2 == $past(pin_in, 2))
      else $error("synchroniser depth wrong");
   a_irq_level: assert property (
      (|(status & mask)) |=> irq)
      else $error("interrupt output not raised");
endmodule : gpm_port
`default_nettype wire

// >>> verification/gpm_board.sv
// Board model: resolves each pin level from the pads, the pulls and external drivers.
`default_nettype none
module gpm_board #(
   parameter int NUM_PINS = 12
) (
   // Clock.
   input wire logic pclk,
   // Pads of the port.
   input var gpm_pkg::gpm_pad_s [NUM_PINS-1:0] pad,
   // External drivers on the board.
   input wire logic [NUM_PINS-1:0] ext_drv,
   input wire logic [NUM_PINS-1:0] ext_val,
   // Levels seen by the port.
   output logic [NUM_PINS-1:0] pin_in
);
   timeunit 1ns;
   timeprecision 1ps;
   import gpm_pkg::*;
   logic [NUM_PINS-1:0] noise = '0;
   // A floating pin changes every cycle so it never passes for a driven level.
   always_ff @(posedge pclk) begin
      noise <= ~noise;
   end
   always_comb begin
      for (int i = 0; i < NUM_PINS; i++) begin
         if (pad[i].oe) pin_in[i] = pad[i].out;
         else if (ext_drv[i]) pin_in[i] = ext_val[i];
         else if (pad[i].pull_up) pin_in[i] = 1'b1;
         else if (pad[i].pull_down) pin_in[i] = 1'b0;
         else pin_in[i] = noise[i];
      end
   end
endmodule : gpm_board
`default_nettype wire

// >>> verification/tb.sv
// Self-checking bench for the pin port: registers, pads, pin mux and pin interrupts.
`default_nettype none
`include "gpm_defines.svh"
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import gpm_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [`GPM_AW-1:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic irq;
   logic [11:0] wake_start;
   logic [11:0] pin_in;
   logic [11:0] ext_drv = '0;
   logic [11:0] ext_val = '0;
   gpm_pad_s [11:0] pad;
   gpm_periph_out_s periph_drive = '0;
   gpm_periph_in_s periph_sense;
   logic [31:0] rd;
   logic perr;
   logic [11:0] outs;
   logic [11:0] oes;
   logic [6:0] tbl [8] = '{7'b1001011, 7'b1000101, 7'b1010011, 7'b1010101,
                           7'b1001100, 7'b0001010, 7'b1101011, 7'b1100101};
   int err_total = 0;
   int num_checks = 0;
   always #2 pclk = ~pclk;
   gpm_port #(.NUM_PINS(12), .START_PINS(12)) u_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(`GPM_STRB_ALL), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .irq(irq), .wake_start(wake_start), .pin_in(pin_in), .pad(pad),
      .periph_drive(periph_drive), .periph_sense(periph_sense));
   gpm_board #(.NUM_PINS(12)) u_board (
      .pclk(pclk), .pad(pad), .ext_drv(ext_drv), .ext_val(ext_val), .pin_in(pin_in));
   always_comb begin
      for (int i = 0; i < 12; i++) begin
         outs[i] = pad[i].out;
         oes[i] = pad[i].oe;
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wt(input int n);
      repeat (n) @(posedge pclk);
      #1;
   endtask : wt
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1);
      rd = prdata;
      perr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      chk(n, 1);
   endtask : apb
   task automatic irq_case(input logic [3:0] m, input logic from, input logic to, input logic ex);
      apb(1'b1, `GPM_OFF_SENSE, {24'h0, m[2], 7'h0});
      apb(1'b1, `GPM_OFF_BOTH, {24'h0, m[1], 7'h0});
      apb(1'b1, `GPM_OFF_POL, {24'h0, m[0], 7'h0});
      apb(1'b1, `GPM_OFF_MASK, {24'h0, m[3], 7'h0});
      ext_val[7] <= from;
      wt(6);
      apb(1'b0, `GPM_OFF_STATUS, 32'h0);
      ext_val[7] <= to;
      wt(6);
      chk(irq, ex);
      apb(1'b0, `GPM_OFF_MSTAT, 32'h0);
      chk(rd, {24'h0, ex, 7'h0});
      apb(1'b0, `GPM_OFF_STATUS, 32'h0);
      apb(1'b0, `GPM_OFF_MSTAT, 32'h0);
      chk(rd, {24'h0, ex & m[2], 7'h0});
      chk(irq, ex & m[2]);
   endtask : irq_case
   task automatic end_test(input string name);
      $display("test %s done", name);
   endtask : end_test
   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : stop_test
   initial begin
      #40000;
      err_total++;
      stop_test();
   end
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      wt(1);
      chk({pad[0].pull_up, pad[0].oe, pad[4]}, 7'h40);
      apb(1'b0, `GPM_OFF_CFG, 32'h0);
      chk(rd, `GPM_CFG_RST_STD);
      apb(1'b0, `GPM_OFF_CFG + 12'h010, 32'h0);
      chk(rd, `GPM_CFG_RST_BUS);
      end_test("reset");
      apb(1'b1, `GPM_OFF_DIR, 32'hfcf);
      apb(1'b1, `GPM_OFF_DATA, 32'ha5a);
      wt(4);
      chk(outs & 12'hfcf, 12'ha4a);
      chk(oes & 12'hfcf, 12'hfcf);
      apb(1'b0, `GPM_OFF_DATA, 32'h0);
      chk(rd & 32'hfcf, 32'ha4a);
      chk(perr, 1'b0);
      apb(1'b1, `GPM_OFF_DIR, 32'h001);
      wt(2);
      chk(oes & 12'hfcf, 12'h001);
      apb(1'b1, `GPM_OFF_DATA, 32'h0);
      apb(1'b1, `GPM_OFF_SET, 32'h00f);
      apb(1'b1, `GPM_OFF_CLR, 32'h005);
      wt(2);
      chk(outs, 12'h00a);
      apb(1'b0, 12'h0fc, 32'h0);
      chk(perr, 1'b1);
      chk(rd, 32'h0);
      end_test("port");
      apb(1'b1, `GPM_OFF_CFG + 12'h004, 32'h18);
      apb(1'b1, `GPM_OFF_DIR, 32'h013);
      apb(1'b1, `GPM_OFF_SET, 32'h012);
      wt(2);
      chk({pad[1].oe, pad[4].oe}, 2'b00);
      apb(1'b1, `GPM_OFF_CLR, 32'h012);
      wt(2);
      chk({pad[1].oe, pad[1].out, pad[4].oe, pad[4].out}, 4'b1010);
      apb(1'b1, `GPM_OFF_CFG + 12'h010, 32'h2c);
      wt(2);
      chk(pad[4].high_sink, 1'b1);
      apb(1'b0, `GPM_OFF_CFG + 12'h010, 32'h0);
      chk(rd, 32'h30);
      apb(1'b1, `GPM_OFF_CFG + 12'h010, 32'h10);
      apb(1'b1, `GPM_OFF_CFG + 12'h00c, 32'h04);
      wt(2);
      chk(pad[4].high_sink, 1'b0);
      chk({pad[3].pull_up, pad[3].pull_down}, 2'b01);
      end_test("pads");
      // Pins are routed before the peripheral drives them.
      apb(1'b1, `GPM_OFF_CFG + 12'h018, 32'h09);
      periph_drive.serial0_shift_clock <= 1'b1;
      periph_drive.serial0_shift_clock_oe <= 1'b1;
      ext_drv[2] <= 1'b1;
      wt(4);
      chk({pad[6].oe, pad[6].out}, 2'b11);
      chk(periph_sense.serial0_shift_clock, 1'b1);
      chk(periph_sense.serial0_slave_select, 1'b1);
      apb(1'b1, `GPM_OFF_CFG + 12'h008, 32'h09);
      wt(4);
      chk(periph_sense.serial0_slave_select, 1'b0);
      apb(1'b1, `GPM_OFF_CFG + 12'h008, 32'h0a);
      ext_val[2] <= 1'b1;
      wt(4);
      chk({periph_sense.timer16_first_capture_in, pad[2].oe}, 2'b10);
      apb(1'b1, `GPM_OFF_CFG + 12'h010, 32'h01);
      ext_drv[4] <= 1'b1;
      wt(4);
      chk({pad[4].oe, periph_sense.bus_clock}, 2'b00);
      end_test("mux");
      @(posedge pclk);
      ext_drv[8] <= 1'b1;
      wt(1);
      chk(wake_start[8], 1'b1);
      wt(3);
      chk(wake_start[8], 1'b0);
      apb(1'b0, `GPM_OFF_WAKE, 32'h0);
      chk(rd[8], 1'b0);
      end_test("wake");
      apb(1'b1, `GPM_OFF_CFG + 12'h01c, 32'h09);
      ext_drv[7] <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         irq_case(tbl[i][6:3], tbl[i][2], tbl[i][1], tbl[i][0]);
      end
      chk(periph_sense.clear_to_send, 1'b0);
      end_test("interrupts");
      stop_test();
   end
endmodule : tb
`default_nettype wire
